// ### common/pbs_pkg.sv
// pbs_pkg: constants and types of the burst / soft-start mode controller
package pbs_pkg;

  // one-hot mode states
  typedef enum logic [4:0] {
    ST_STOP      = 5'h01,
    ST_BURST_OFF = 5'h02,
    ST_SOFT_ON   = 5'h04,
    ST_RUN       = 5'h08,
    ST_SOFT_OFF  = 5'h10
  } pbs_state_t;

  // widths
  localparam int unsigned DEMAND_W = 8;
  localparam int unsigned THR_W = 8;
  localparam int unsigned RAMP_W = 2;

  // soft ramp length in switching cycles
  localparam logic [RAMP_W-1:0] RAMP_LAST = 2'h3;
  localparam logic [2:0] RAMP_FULL = 3'h4;

  // burst threshold codes, full scale 0xFF = maximum compensation voltage
  // group 0: average 0x1C, about 11 percent of full scale
  localparam logic [THR_W-1:0] BURST_HIGH_G0 = 8'h20;
  localparam logic [THR_W-1:0] BURST_LOW_G0 = 8'h18;
  // group 1: average 0x28, about 16 percent of full scale
  localparam logic [THR_W-1:0] BURST_HIGH_G1 = 8'h2C;
  localparam logic [THR_W-1:0] BURST_LOW_G1 = 8'h24;

  // reset values
  localparam logic [DEMAND_W-1:0] TON_RESET = 8'h00;
  localparam logic [RAMP_W-1:0] RAMP_RESET = 2'h0;
  localparam logic [1:0] SYNC_RESET = 2'h0;

endpackage : pbs_pkg

// ### hdl/pbs_mode_ctrl.sv
// pbs_mode_ctrl: stop / burst / soft-start mode state machine
//
// Function
// R1: stay in stop until the line-start comparator reports the line-start threshold is exceeded.
// R2: once switching, ignore line voltage; only a fault returns the controller to stop.
// R3: each burst-on period ramps on-time up over four cycles, down over four.
// R4: burst-low comparator trip gives four soft-off cycles, then switching stops.
// R5: burst-high comparator trip restarts switching with four soft-on cycles.
// R6: burst thresholds chosen per variant group, averaging about 11 or 16 percent.
// R7: in stop, connect the compensation discharge resistor to ground.
// R8: start-up goes stop to burst-off; switching waits for the burst-high comparator.
// R9: first switching starts near 12.5 percent demand, ramped up over four cycles; the code starts at one quarter (25 percent) of demand.
// R10: enable the error amplifier fast transient gain during start-up.
// R11: overvoltage trip moves run to burst-off; run resumes only after release.
// R12: ramp steps scale demand in quarters, counted by a two-bit cycle counter.
`timescale 1ns/1ns

module pbs_mode_ctrl (
  // clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // analog comparator results (asynchronous)
  input wire logic line_start_cmp_in,
  input wire logic burst_high_cmp_in,
  input wire logic burst_low_cmp_in,
  input wire logic ovp_cmp_in,
  // fault request and switching-cycle marker (asynchronous)
  input wire logic fault_in,
  input wire logic sw_cycle_in,
  // variant strap, 0 = 11 percent group, 1 = 16 percent group
  input wire logic variant_sel_in,
  // on-time demand from the error amplifier
  input wire logic [pbs_pkg::DEMAND_W-1:0] demand_in,
  // gate driver pacing
  output logic gate_enable_out,
  output logic [pbs_pkg::DEMAND_W-1:0] ton_width_out,
  // analog controls
  output logic comp_discharge_out,
  output logic fast_gain_out,
  output logic [pbs_pkg::THR_W-1:0] burst_high_threshold_out,
  output logic [pbs_pkg::THR_W-1:0] burst_low_threshold_out,
  // state observation
  output logic [4:0] state_out
);

  ////////////////////////////////////////////////////////////////////////////
  // state record

  typedef struct packed {
    logic [1:0] line_sync;
    logic [1:0] high_sync;
    logic [1:0] low_sync;
    logic [1:0] ovp_sync;
    logic [1:0] fault_sync;
    logic [1:0] cyc_sync;
    logic [1:0] var_sync;
    logic cyc_prev;
    logic var_taken;
    logic variant;
    pbs_pkg::pbs_state_t state;
    logic [pbs_pkg::RAMP_W-1:0] ramp;
    logic gate_en;
    logic [pbs_pkg::DEMAND_W-1:0] ton;
    logic discharge;
    logic fast_gain;
    logic [pbs_pkg::THR_W-1:0] thr_high;
    logic [pbs_pkg::THR_W-1:0] thr_low;
  } pbs_regs_t;

  pbs_regs_t regs_q;
  pbs_regs_t regs_d;

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  logic line_ok;
  logic burst_high;
  logic burst_low;
  logic ovp;
  logic fault;
  logic cyc_pulse;
  logic ramp_done;
  logic [2:0] quarters;
  logic [10:0] scaled;

  always_comb begin
    regs_d = regs_q;
    // second stage of each synchroniser is the only one read
    line_ok = regs_q.line_sync[1];
    burst_high = regs_q.high_sync[1];
    burst_low = regs_q.low_sync[1];
    ovp = regs_q.ovp_sync[1];
    fault = regs_q.fault_sync[1];
    cyc_pulse = regs_q.cyc_sync[1] & ~regs_q.cyc_prev;
    ramp_done = cyc_pulse & (regs_q.ramp == pbs_pkg::RAMP_LAST);
    quarters = pbs_pkg::RAMP_FULL;
    regs_d.line_sync = {regs_q.line_sync[0], line_start_cmp_in};
    regs_d.high_sync = {regs_q.high_sync[0], burst_high_cmp_in};
    regs_d.low_sync = {regs_q.low_sync[0], burst_low_cmp_in};
    regs_d.ovp_sync = {regs_q.ovp_sync[0], ovp_cmp_in};
    regs_d.fault_sync = {regs_q.fault_sync[0], fault_in};
    regs_d.cyc_sync = {regs_q.cyc_sync[0], sw_cycle_in};
    regs_d.var_sync = {regs_q.var_sync[0], variant_sel_in};
    regs_d.cyc_prev = regs_q.cyc_sync[1];

    // strap follows the synchroniser until the controller first leaves stop, then is held
    if (!regs_q.var_taken && regs_q.state != pbs_pkg::ST_STOP) begin
      regs_d.var_taken = 1'b1;
    end
    if (!regs_q.var_taken) begin
      regs_d.variant = regs_q.var_sync[1];
    end
    regs_d.thr_high = regs_q.variant ? pbs_pkg::BURST_HIGH_G1 : pbs_pkg::BURST_HIGH_G0; // [R6]
    regs_d.thr_low = regs_q.variant ? pbs_pkg::BURST_LOW_G1 : pbs_pkg::BURST_LOW_G0; // [R6]

    // two-bit counter steps once per switching cycle while ramping
    if (cyc_pulse) begin
      regs_d.ramp = regs_q.ramp + 2'h1; // [R12]
    end

    unique case (regs_q.state)
      pbs_pkg::ST_STOP: begin
        regs_d.ramp = pbs_pkg::RAMP_RESET;
        if (line_ok && !fault) begin
          regs_d.state = pbs_pkg::ST_BURST_OFF; // [R1] [R8]
          regs_d.fast_gain = 1'b1; // [R10]
        end
      end
      pbs_pkg::ST_BURST_OFF: begin
        regs_d.ramp = pbs_pkg::RAMP_RESET;
        if (burst_high && !ovp) begin
          regs_d.state = pbs_pkg::ST_SOFT_ON; // [R5] [R8] [R11]
        end
      end
      pbs_pkg::ST_SOFT_ON: begin
        // ramp scale is taken from the loaded count below
        if (ramp_done) begin
          regs_d.state = pbs_pkg::ST_RUN;
          regs_d.fast_gain = 1'b0;
        end
      end
      pbs_pkg::ST_RUN: begin
        regs_d.ramp = pbs_pkg::RAMP_RESET;
        // line voltage is not looked at while switching
        if (burst_low || ovp) begin
          regs_d.state = pbs_pkg::ST_SOFT_OFF; // [R2] [R4] [R11]
        end
      end
      pbs_pkg::ST_SOFT_OFF: begin
        // ramp scale is taken from the loaded count below
        if (ramp_done) begin
          regs_d.state = pbs_pkg::ST_BURST_OFF; // [R4] [R11]
        end
      end
      default: begin
        regs_d.state = pbs_pkg::ST_STOP;
      end
    endcase

    // a fault forces stop from any state
    if (fault) begin
      regs_d.state = pbs_pkg::ST_STOP; // [R2]
      regs_d.fast_gain = 1'b0;
    end

    // scale follows the state and count being loaded, so the first soft-on
    // pulse is already one quarter and no full-width pulse slips out
    if (regs_d.state == pbs_pkg::ST_SOFT_ON) begin
      quarters = {1'b0, regs_d.ramp} + 3'h1; // [R3] [R9] [R12]
    end else if (regs_d.state == pbs_pkg::ST_SOFT_OFF) begin
      quarters = pbs_pkg::RAMP_FULL - {1'b0, regs_d.ramp}; // [R3] [R4] [R12]
    end

    scaled = {1'b0, demand_in} * {8'h00, quarters};
    regs_d.gate_en = (regs_d.state == pbs_pkg::ST_SOFT_ON) ||
                     (regs_d.state == pbs_pkg::ST_RUN) ||
                     (regs_d.state == pbs_pkg::ST_SOFT_OFF);
    regs_d.ton = regs_d.gate_en ? scaled[9:2] : pbs_pkg::TON_RESET; // [R12]
    regs_d.discharge = (regs_d.state == pbs_pkg::ST_STOP); // [R7]
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      regs_q.line_sync <= pbs_pkg::SYNC_RESET;
      regs_q.high_sync <= pbs_pkg::SYNC_RESET;
      regs_q.low_sync <= pbs_pkg::SYNC_RESET;
      regs_q.ovp_sync <= pbs_pkg::SYNC_RESET;
      regs_q.fault_sync <= pbs_pkg::SYNC_RESET;
      regs_q.cyc_sync <= pbs_pkg::SYNC_RESET;
      regs_q.var_sync <= pbs_pkg::SYNC_RESET;
      regs_q.cyc_prev <= 1'b0;
      regs_q.var_taken <= 1'b0;
      regs_q.variant <= 1'b0;
      regs_q.state <= pbs_pkg::ST_STOP;
      regs_q.ramp <= pbs_pkg::RAMP_RESET;
      regs_q.gate_en <= 1'b0;
      regs_q.ton <= pbs_pkg::TON_RESET;
      regs_q.discharge <= 1'b1;
      regs_q.fast_gain <= 1'b0;
      regs_q.thr_high <= pbs_pkg::BURST_HIGH_G0;
      regs_q.thr_low <= pbs_pkg::BURST_LOW_G0;
    end else begin
      regs_q <= regs_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign gate_enable_out = regs_q.gate_en;
  assign ton_width_out = regs_q.ton;
  assign comp_discharge_out = regs_q.discharge;
  assign fast_gain_out = regs_q.fast_gain;
  assign burst_high_threshold_out = regs_q.thr_high;
  assign burst_low_threshold_out = regs_q.thr_low;
  assign state_out = regs_q.state;

endmodule : pbs_mode_ctrl

// ### sim/pbs_mode_ctrl_properties.sv
// checker: port properties of the mode controller
`timescale 1ns/1ns
module pbs_mode_ctrl_props (
  input wire logic mclk_in, sys_rst_in, line_start_cmp_in, burst_high_cmp_in,
  input wire logic burst_low_cmp_in, ovp_cmp_in, fault_in, gate_enable_out,
  input wire logic comp_discharge_out,
  input wire logic [4:0] state_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  // state moves from a to b at this edge
  sequence s_step(logic [4:0] a, logic [4:0] b);
    $past(state_out) == a && state_out == b;
  endsequence
  a_stop_discharge: assert property (comp_discharge_out == (state_out == 5'h01))
    else $error("bad discharge");
  a_gate_switching: assert property (gate_enable_out == |state_out[4:2])
    else $error("bad gate enable");
  a_stop_exit: assert property (s_step(5'h01, 5'h02) |-> $past(line_start_cmp_in, 2))
    else $error("early stop exit");
  a_burst_restart: assert property (s_step(5'h02, 5'h04) |-> $past(burst_high_cmp_in, 2))
    else $error("restart without cause");
  a_softon_len: assert property (s_step(5'h04, 5'h08) |-> $past(state_out, 8) == 5'h04)
    else $error("soft-on too short");
  a_softoff_len: assert property (s_step(5'h10, 5'h02) |-> $past(state_out, 8) == 5'h10)
    else $error("soft-off too short");
  a_run_exit: assert property (s_step(5'h08, 5'h10) |->
    $past(burst_low_cmp_in, 2) || $past(ovp_cmp_in, 2)) else $error("run exit without cause");
  a_fault_stop: assert property (fault_in |-> ##[2:3] state_out == 5'h01)
    else $error("fault ignored");
endmodule : pbs_mode_ctrl_props
bind pbs_mode_ctrl pbs_mode_ctrl_props pbs_mode_ctrl_props_i (.*);

// ### sim/pbs_plant_model.sv
// far-side model: switching-cycle marker of the boost stage
`timescale 1ns/1ns
module pbs_plant_model #(parameter int HALF = 4) (
  input wire logic mclk_in,
  input wire logic gate_enable_in,
  output logic sw_cycle_out = 1'b0
);
  int cnt = 0;
  // marker still outside switching; a started high phase completes
  always @(negedge mclk_in) begin
    if (!gate_enable_in && !sw_cycle_out) begin
      cnt <= 0;
    end else begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) sw_cycle_out <= !sw_cycle_out;
    end
  end
endmodule : pbs_plant_model

// ### sim/test_pbs_mode_ctrl.sv
// self-checking bench of the mode controller
`timescale 1ns/1ns
module test_pbs_mode_ctrl;
  logic mclk_in = 1'b0, sys_rst_in = 1'b1, variant_sel_in = 1'b0, sw_cycle_in;
  logic line_start_cmp_in = 1'b0, burst_high_cmp_in = 1'b0, burst_low_cmp_in = 1'b0;
  logic ovp_cmp_in = 1'b0, fault_in = 1'b0, gate_enable_out, comp_discharge_out, fast_gain_out;
  logic [7:0] demand_in = 8'h40, ton_width_out, burst_high_threshold_out, burst_low_threshold_out;
  logic [4:0] state_out;
  int fail_count = 0, n_checks = 0;
  always #50 mclk_in = ~mclk_in;
  pbs_mode_ctrl pbs_mode_ctrl_i (.*);
  pbs_plant_model pbs_plant_model_i (.mclk_in, .gate_enable_in(gate_enable_out),
    .sw_cycle_out(sw_cycle_in));
  ////////////////////
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wait_st(input logic [4:0] st);
    for (int i = 0; i < 300 && state_out !== st; i++) @(negedge mclk_in);
    chk(16'(state_out), 16'(st));
  endtask : wait_st
  task automatic wait_ton(input logic [7:0] e);
    for (int i = 0; i < 40 && ton_width_out !== e; i++) @(negedge mclk_in);
    chk(16'(ton_width_out), 16'(e));
  endtask : wait_ton
  task automatic t_reset(input logic v);
    {sys_rst_in, variant_sel_in} = {1'b1, v};
    {line_start_cmp_in, burst_high_cmp_in, burst_low_cmp_in, ovp_cmp_in, fault_in} = 5'h00;
    repeat (8) @(negedge mclk_in);
    sys_rst_in = 1'b0;
    chk(16'({state_out, comp_discharge_out, gate_enable_out}), 16'h0006);
    // strap needs two sync edges, one capture edge and one output edge
    repeat (4) @(negedge mclk_in);
    chk({burst_high_threshold_out, burst_low_threshold_out}, v ? 16'h2C24 : 16'h2018);
    $display("reset test done");
  endtask : t_reset
  task automatic t_brownin;
    repeat (20) @(negedge mclk_in);
    chk(16'(state_out), 16'h0001);
    line_start_cmp_in = 1'b1;
    wait_st(5'h02);
    chk(16'({fast_gain_out, comp_discharge_out}), 16'h0002);
    repeat (20) @(negedge mclk_in);
    chk(16'(state_out), 16'h0002);
    $display("brown-in test done");
  endtask : t_brownin
  task automatic t_burst;
    burst_high_cmp_in = 1'b1;
    wait_st(5'h04);
    chk(16'(ton_width_out), 16'h0010);
    line_start_cmp_in = 1'b0;
    wait_ton(8'h20);
    wait_ton(8'h30);
    wait_ton(8'h40);
    wait_st(5'h08);
    chk(16'({fast_gain_out, ton_width_out}), 16'h0040);
    {burst_high_cmp_in, burst_low_cmp_in} = 2'b01;
    wait_st(5'h10);
    chk(16'(ton_width_out), 16'h0040);
    wait_ton(8'h30);
    wait_ton(8'h20);
    wait_ton(8'h10);
    wait_st(5'h02);
    chk(16'({gate_enable_out, ton_width_out}), 16'h0000);
    burst_low_cmp_in = 1'b0;
    $display("burst test done");
  endtask : t_burst
  task automatic t_protect;
    burst_high_cmp_in = 1'b1;
    wait_st(5'h08);
    ovp_cmp_in = 1'b1;
    wait_st(5'h02);
    repeat (20) @(negedge mclk_in);
    chk(16'(state_out), 16'h0002);
    ovp_cmp_in = 1'b0;
    wait_st(5'h04);
    fault_in = 1'b1;
    wait_st(5'h01);
    $display("protection test done");
  endtask : t_protect
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    t_reset(1'b0);
    t_brownin;
    t_burst;
    t_protect;
    t_reset(1'b1);
    tally_and_finish;
  end
  initial begin
    #2000000;
    fail_count++;
    tally_and_finish;
  end
endmodule : test_pbs_mode_ctrl
